// file: design/sac_ctrl.sv
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "sac_defines.svh"

module sac_ctrl
    import sac_pkg::*;
#(
    parameter int RES_W = 8,
    parameter int PORT_W = 8
)
(
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic [7:0]        paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Analog front end
    input  wire logic              cmp_in,
    output logic                   adc_en,
    output logic [2:0]             chan_sel,
    output logic [3:0]             ref_hi_sel,
    output logic                   sample_en,
    output logic [RES_W-1:0]       dac_code,
    // Shared port pins
    input  wire logic [PORT_W-1:0] pa_pin,
    input  wire logic [PORT_W-1:0] pb_pin,
    output logic [PORT_W-1:0]      pa_din_en,
    output logic [PORT_W-1:0]      pb_din_en,
    // Interrupt
    output logic                   irq
);

    generate
        if (RES_W != 8 || PORT_W < 1 || PORT_W > 8)
        begin : g_bad_par
            $error("sac_ctrl: RES_W must be 8 and PORT_W 1..8");
        end
    endgenerate

    // Divider terminal count for a divider code
    function automatic logic [6:0] div_limit(input logic [2:0] code);
        div_limit = 7'((8'h01 << code) - 8'h01);
    endfunction

    // Address decode
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `SAC_OFF_CTRL)     || (a == `SAC_OFF_MODE)    ||
                    (a == `SAC_OFF_RESULT)   || (a == `SAC_OFF_REFHI)   ||
                    (a == `SAC_OFF_PA_DIER)  || (a == `SAC_OFF_PB_DIER) ||
                    (a == `SAC_OFF_PA_DATA)  || (a == `SAC_OFF_PB_DATA) ||
                    (a == `SAC_OFF_IRQ_STAT) || (a == `SAC_OFF_IRQ_MASK);
    endfunction

    // Register state
    logic              en_q;
    logic              en_d;
    logic [2:0]        ch_q;
    logic [2:0]        ch_d;
    logic [2:0]        div_q;
    logic [2:0]        div_d;
    logic [3:0]        refhi_q;
    logic [3:0]        refhi_d;
    logic [PORT_W-1:0] pa_dier_q;
    logic [PORT_W-1:0] pa_dier_d;
    logic [PORT_W-1:0] pb_dier_q;
    logic [PORT_W-1:0] pb_dier_d;
    logic              stat_q;
    logic              stat_d;
    logic              mask_q;
    logic              mask_d;
    logic [RES_W-1:0]  result_q;
    logic [RES_W-1:0]  result_d;
    logic [31:0]       prdata_q;
    logic [31:0]       prdata_d;
    logic [6:0]        div_cnt_q;
    logic [6:0]        div_cnt_d;

    // Synchronisers
    logic              cmp_meta_q;
    logic              cmp_sync_q;
    logic [PORT_W-1:0] pa_meta_q;
    logic [PORT_W-1:0] pa_sync_q;
    logic [PORT_W-1:0] pb_meta_q;
    logic [PORT_W-1:0] pb_sync_q;

    // Bus strobes and engine links
    logic              access;
    logic              wr;
    logic              busy;
    logic              done;
    logic              start;
    logic              abort;
    logic              conv_clock_tick;
    logic [RES_W-1:0]  trial_code;
    logic [31:0]       rd_mux;

    assign access  = psel & penable;
    assign wr      = access & pwrite & pstrb[0];
    assign pready  = 1'b1;
    assign pslverr = access & ~is_mapped(paddr);

    // Start only with enable set in the same write and engine idle
    assign start = wr && (paddr == `SAC_OFF_CTRL) && !busy &&
                   pwdata[`SAC_CTRL_START_BIT] &&
                   pwdata[`SAC_CTRL_EN_BIT];
    assign abort = ~en_q;

    // Conversion clock divider, restarted at every start
    always_comb
    begin
        if (!busy)
        begin
            div_cnt_d = 7'h00;
        end
        else if (div_cnt_q == div_limit(div_q))
        begin
            div_cnt_d = 7'h00;
        end
        else
        begin
            div_cnt_d = div_cnt_q + 7'h01;
        end
    end

    assign conv_clock_tick = busy && (div_cnt_q == div_limit(div_q));

    sac_sar #(
        .RES_W (RES_W)
    ) u_sar (
        .pclk       (pclk),
        .presetn    (presetn),
        .tick       (conv_clock_tick),
        .start      (start),
        .abort      (abort),
        .cmp        (cmp_sync_q),
        .busy       (busy),
        .done       (done),
        .sample     (sample_en),
        .trial_code (trial_code)
    );

    // Register writes and hardware updates
    always_comb
    begin
        en_d      = en_q;
        ch_d      = ch_q;
        div_d     = div_q;
        refhi_d   = refhi_q;
        pa_dier_d = pa_dier_q;
        pb_dier_d = pb_dier_q;
        mask_d    = mask_q;
        result_d  = result_q;
        if (wr)
        begin
            unique case (paddr)
                `SAC_OFF_CTRL:
                begin
                    en_d = pwdata[`SAC_CTRL_EN_BIT];
                    ch_d = pwdata[`SAC_CTRL_CH_LSB +: 3];
                end
                `SAC_OFF_MODE:
                begin
                    div_d = pwdata[`SAC_MODE_DIV_LSB +: 3];
                end
                `SAC_OFF_REFHI:
                begin
                    refhi_d = pwdata[`SAC_REFHI_LSB +: 4];
                end
                `SAC_OFF_PA_DIER:
                begin
                    pa_dier_d = pwdata[PORT_W-1:0];
                end
                `SAC_OFF_PB_DIER:
                begin
                    pb_dier_d = pwdata[PORT_W-1:0];
                end
                `SAC_OFF_IRQ_MASK:
                begin
                    mask_d = pwdata[`SAC_IRQ_DONE_BIT];
                end
                default:
                begin
                end
            endcase
        end
        if (done)
        begin
            result_d = trial_code;
        end
        // Completion wins over a clearing write in the same cycle
        stat_d = (stat_q & ~(wr && (paddr == `SAC_OFF_IRQ_STAT) &&
                              pwdata[`SAC_IRQ_DONE_BIT])) | done;
    end

    // Read mux, loaded in the setup phase
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            `SAC_OFF_CTRL:
            begin
                rd_mux[`SAC_CTRL_EN_BIT]      = en_q;
                rd_mux[`SAC_CTRL_START_BIT]   = ~busy;
                rd_mux[`SAC_CTRL_CH_LSB +: 3] = ch_q;
            end
            `SAC_OFF_MODE:
            begin
                rd_mux[`SAC_MODE_DIV_LSB +: 3] = div_q;
            end
            `SAC_OFF_RESULT:
            begin
                rd_mux[RES_W-1:0] = result_q;
            end
            `SAC_OFF_REFHI:
            begin
                rd_mux[`SAC_REFHI_LSB +: 4] = refhi_q;
            end
            `SAC_OFF_PA_DIER:
            begin
                rd_mux[PORT_W-1:0] = pa_dier_q;
            end
            `SAC_OFF_PB_DIER:
            begin
                rd_mux[PORT_W-1:0] = pb_dier_q;
            end
            `SAC_OFF_PA_DATA:
            begin
                rd_mux[PORT_W-1:0] = pa_sync_q & pa_dier_q;
            end
            `SAC_OFF_PB_DATA:
            begin
                rd_mux[PORT_W-1:0] = pb_sync_q & pb_dier_q;
            end
            `SAC_OFF_IRQ_STAT:
            begin
                rd_mux[`SAC_IRQ_DONE_BIT] = stat_q;
            end
            `SAC_OFF_IRQ_MASK:
            begin
                rd_mux[`SAC_IRQ_DONE_BIT] = mask_q;
            end
            default:
            begin
            end
        endcase
        prdata_d = prdata_q;
        if (psel && !penable && !pwrite)
        begin
            prdata_d = rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_q       <= `SAC_CTRL_EN_RST;
            ch_q       <= `SAC_CH_RST;
            div_q      <= `SAC_DIV_RST;
            refhi_q    <= `SAC_REFHI_RST;
            pa_dier_q  <= PORT_W'(`SAC_DIER_RST);
            pb_dier_q  <= PORT_W'(`SAC_DIER_RST);
            stat_q     <= `SAC_IRQ_RST;
            mask_q     <= `SAC_IRQ_RST;
            result_q   <= RES_W'(`SAC_RESULT_RST);
            prdata_q   <= 32'h0000_0000;
            div_cnt_q  <= 7'h00;
            cmp_meta_q <= 1'b0;
            cmp_sync_q <= 1'b0;
            pa_meta_q  <= '0;
            pa_sync_q  <= '0;
            pb_meta_q  <= '0;
            pb_sync_q  <= '0;
        end
        else
        begin
            en_q       <= en_d;
            ch_q       <= ch_d;
            div_q      <= div_d;
            refhi_q    <= refhi_d;
            pa_dier_q  <= pa_dier_d;
            pb_dier_q  <= pb_dier_d;
            stat_q     <= stat_d;
            mask_q     <= mask_d;
            result_q   <= result_d;
            prdata_q   <= prdata_d;
            div_cnt_q  <= div_cnt_d;
            cmp_meta_q <= cmp_in;
            cmp_sync_q <= cmp_meta_q;
            pa_meta_q  <= pa_pin;
            pa_sync_q  <= pa_meta_q;
            pb_meta_q  <= pb_pin;
            pb_sync_q  <= pb_meta_q;
        end
    end

    // Outputs
    assign prdata     = prdata_q;
    assign adc_en     = en_q;
    assign chan_sel   = ch_q;
    assign ref_hi_sel = refhi_q;
    assign dac_code   = trial_code;
    assign pa_din_en  = pa_dier_q;
    assign pb_din_en  = pb_dier_q;
    assign irq        = stat_q & mask_q;

endmodule // sac_ctrl

`default_nettype wire

// file: design/sac_defines.svh
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH

// Register byte offsets
`define SAC_OFF_CTRL      8'h00
`define SAC_OFF_MODE      8'h04
`define SAC_OFF_RESULT    8'h08
`define SAC_OFF_REFHI     8'h0C
`define SAC_OFF_PA_DIER   8'h10
`define SAC_OFF_PB_DIER   8'h14
`define SAC_OFF_PA_DATA   8'h18
`define SAC_OFF_PB_DATA   8'h1C
`define SAC_OFF_IRQ_STAT  8'h20
`define SAC_OFF_IRQ_MASK  8'h24

// Field positions
`define SAC_CTRL_EN_BIT     7
`define SAC_CTRL_START_BIT  6
`define SAC_CTRL_CH_LSB     0
`define SAC_MODE_DIV_LSB    0
`define SAC_REFHI_LSB       0
`define SAC_IRQ_DONE_BIT    3

// Reset values
`define SAC_CTRL_EN_RST   1'b0
`define SAC_CH_RST        3'h0
`define SAC_DIV_RST       3'h0
`define SAC_REFHI_RST     4'h0
`define SAC_DIER_RST      8'hFF
`define SAC_IRQ_RST       1'b0
`define SAC_RESULT_RST    8'h00

// Timing in conversion clock periods
`define SAC_ACQ_PERIODS   1
`define SAC_HOLD_PERIODS  1
`define SAC_FIN_PERIODS   2
`define SAC_CONV_PERIODS  12

`endif

// file: design/sac_pkg.sv
package sac_pkg;

    // Conversion sequencer states, Gray along the usual path from SAC_IDLE to SAC_FIN
    typedef enum logic [2:0] {
        SAC_IDLE = 3'b000,
        SAC_ACQ  = 3'b001,
        SAC_HOLD = 3'b011,
        SAC_BITS = 3'b010,
        SAC_FIN  = 3'b110
    } sac_state_e;

    typedef logic [7:0] sac_byte_t;

endpackage

// file: design/sac_sar.sv
`timescale 1ns/100ps
`default_nettype none
`include "sac_defines.svh"

module sac_sar
    import sac_pkg::*;
#(
    parameter int RES_W = 8
)
(
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Control from the register side
    input  wire logic             tick,
    input  wire logic             start,
    input  wire logic             abort,
    input  wire logic             cmp,
    // Status and analog controls
    output logic                  busy,
    output logic                  done,
    output logic                  sample,
    output logic [RES_W-1:0]      trial_code
);

    localparam int BW = (RES_W > 1) ? $clog2(RES_W) : 1;

    generate
        if (RES_W != `SAC_CONV_PERIODS - `SAC_ACQ_PERIODS
                     - `SAC_HOLD_PERIODS - `SAC_FIN_PERIODS)
        begin : g_bad_res
            $error("sac_sar: RES_W must fill the conversion period count");
        end
    endgenerate

    sac_state_e       state_q;
    sac_state_e       state_d;
    logic [BW-1:0]    bit_q;
    logic [BW-1:0]    bit_d;
    logic [RES_W-1:0] code_q;
    logic [RES_W-1:0] code_d;
    logic             fin_q;
    logic             fin_d;

    always_comb
    begin
        state_d = state_q;
        bit_d   = bit_q;
        code_d  = code_q;
        fin_d   = fin_q;
        done    = 1'b0;
        unique case (state_q)
            SAC_IDLE:
            begin
                if (start)
                begin
                    state_d = SAC_ACQ;
                    code_d  = '0;
                end
            end
            SAC_ACQ:
            begin
                // One period of acquisition only
                if (tick)
                begin
                    state_d = SAC_HOLD;
                end
            end
            SAC_HOLD:
            begin
                if (tick)
                begin
                    state_d            = SAC_BITS;
                    bit_d              = BW'(RES_W - 1);
                    code_d[RES_W-1]    = 1'b1;
                end
            end
            SAC_BITS:
            begin
                // Keep trial bit when input is at or above the trial level
                if (tick)
                begin
                    if (!cmp)
                    begin
                        code_d[bit_q] = 1'b0;
                    end
                    if (bit_q == '0)
                    begin
                        state_d = SAC_FIN;
                        fin_d   = 1'b0;
                    end
                    else
                    begin
                        bit_d                 = bit_q - 1'b1;
                        code_d[bit_q - 1'b1]  = 1'b1;
                    end
                end
            end
            SAC_FIN:
            begin
                if (tick)
                begin
                    if (fin_q)
                    begin
                        state_d = SAC_IDLE;
                        done    = 1'b1;
                    end
                    else
                    begin
                        fin_d = 1'b1;
                    end
                end
            end
        endcase
        if (abort && state_q != SAC_IDLE)
        begin
            state_d = SAC_IDLE;
            done    = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= SAC_IDLE;
            bit_q   <= '0;
            code_q  <= '0;
            fin_q   <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            bit_q   <= bit_d;
            code_q  <= code_d;
            fin_q   <= fin_d;
        end
    end

    assign busy       = (state_q != SAC_IDLE);
    assign sample     = (state_q == SAC_ACQ);
    assign trial_code = code_q;

endmodule // sac_sar

`default_nettype wire

// file: verification/sac_ctrl_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "sac_defines.svh"
module sac_ctrl_asserts
    import sac_pkg::*;
#(
    parameter int RES_W  = 8,
    parameter int PORT_W = 8
)
(
    // Clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // APB
    input wire logic [7:0]        paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Analog and pins
    input wire logic              cmp_in,
    input wire logic              adc_en,
    input wire logic [2:0]        chan_sel,
    input wire logic [3:0]        ref_hi_sel,
    input wire logic              sample_en,
    input wire logic [RES_W-1:0]  dac_code,
    input wire logic [PORT_W-1:0] pa_pin,
    input wire logic [PORT_W-1:0] pb_pin,
    input wire logic [PORT_W-1:0] pa_din_en,
    input wire logic [PORT_W-1:0] pb_din_en,
    input wire logic              irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr;
    assign wr = psel && penable && pwrite && pstrb[0];
    chk_en_write: assert property (wr && paddr == 8'h00 |=>
        adc_en == $past(pwdata[7])) else $error("enable not written");
    chk_chan_write: assert property (wr && paddr == 8'h00 |=>
        chan_sel == $past(pwdata[2:0])) else $error("channel not written");
    chk_refhi_write: assert property (wr && paddr == 8'h0C |=>
        ref_hi_sel == $past(pwdata[3:0])) else $error("refhi not written");
    chk_pa_dier: assert property (wr && paddr == 8'h10 |=>
        pa_din_en == $past(pwdata[7:0])) else $error("pa dier not written");
    chk_pb_dier: assert property (wr && paddr == 8'h14 |=>
        pb_din_en == $past(pwdata[7:0])) else $error("pb dier not written");
    chk_sample_cause: assert property ($rose(sample_en) |->
        $past(wr && paddr == 8'h00 && pwdata[7:6] == 2'b11))
        else $error("sampling without start");
    chk_sample_en: assert property (sample_en |-> adc_en)
        else $error("sampling while disabled");
    chk_mask_off: assert property (wr && paddr == 8'h24 && !pwdata[3]
        |=> !irq) else $error("masked irq high");
    chk_irq_sticky: assert property (irq && !(wr && paddr inside
        {8'h20, 8'h24}) |=> irq) else $error("irq dropped");
    chk_irq_cause: assert property ($rose(irq) |-> $past(adc_en) ||
        $past(wr && paddr == 8'h24)) else $error("irq without cause");
    cover property ($rose(irq));
    cover property ($fell(sample_en));
    cover property (psel && penable && pslverr);
endmodule // sac_ctrl_asserts
`default_nettype wire

// file: verification/sac_analog_model.sv
`timescale 1ns/100ps
`default_nettype none
module sac_analog_model
(
    // Clock
    input wire logic        pclk,
    // Converter side
    input wire logic        sample_en,
    input wire logic [2:0]  chan_sel,
    input wire logic [7:0]  dac_code,
    input wire logic [63:0] levels,
    output logic            cmp_in
);
    logic [7:0] held_q;
    // Track input while sampling, hold after
    always_ff @(posedge pclk)
    begin
        if (sample_en)
            held_q <= levels[chan_sel*8 +: 8];
    end
    // Levels in codes above ground
    assign cmp_in = (held_q >= dac_code);
endmodule // sac_analog_model
`default_nettype wire

// file: verification/sac_ctrl_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "sac_defines.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module sac_ctrl_test;
    localparam logic [63:0] LV = {8'h3C, 8'h7F, 8'h80, 8'hA5,
                                  8'h5A, 8'h81, 8'h00, 8'hFF};
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0, pa_pin = 0, pb_pin = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [3:0]  pstrb = 0, ref_hi_sel;
    logic [3:0]  strb = 4'hF;
    logic        pready, pslverr, cmp_in, adc_en, sample_en, irq, er;
    logic [2:0]  chan_sel;
    logic [7:0]  dac_code, pa_din_en, pb_din_en;
    int          n_errors = 0, n_tests = 0, cyc = 0;
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    sac_ctrl #(.RES_W(8), .PORT_W(8)) dut (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp_in(cmp_in), .adc_en(adc_en),
        .chan_sel(chan_sel), .ref_hi_sel(ref_hi_sel), .sample_en(sample_en),
        .dac_code(dac_code), .pa_pin(pa_pin), .pb_pin(pb_pin),
        .pa_din_en(pa_din_en), .pb_din_en(pb_din_en), .irq(irq));
    sac_analog_model u_ana (.pclk(pclk), .sample_en(sample_en),
        .chan_sel(chan_sel), .dac_code(dac_code), .levels(LV),
        .cmp_in(cmp_in));
    task summarize;
        if (n_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // One APB transfer, answer taken at the pready edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w;
        paddr <= a; pwdata <= d; pstrb <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task conv(input int ch, input int dv);
        int t0, ns;
        apb(1, `SAC_OFF_MODE, dv);
        apb(1, `SAC_OFF_CTRL, 32'hC0 | ch);
        #1;
        t0 = cyc;
        ns = 0;
        while (irq !== 1'b1 && cyc - t0 < 4000)
        begin
            if (sample_en === 1'b1)
                ns++;
            @(posedge pclk);
            #1;
        end
        `CHK(cyc - t0, 12 << dv)
        `CHK(ns, 1 << dv)
        apb(0, `SAC_OFF_CTRL, 0); `CHK(rd, 32'hC0 | ch)
        apb(0, `SAC_OFF_RESULT, 0);
        if (dv >= 2) `CHK(rd, {24'h0, LV[ch*8 +: 8]})
        apb(0, `SAC_OFF_IRQ_STAT, 0); `CHK(rd, 32'h8)
        apb(1, `SAC_OFF_IRQ_STAT, 32'h8); #1; `CHK(irq, 1'b0)
    endtask
    initial
    begin
        #(25 * 20000);
        n_errors++;
        summarize();
    end
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        pa_pin <= 8'hFF;
        pb_pin <= 8'hA5;
        #1;
        `CHK({adc_en, irq, pa_din_en}, 10'h0FF)
        apb(0, `SAC_OFF_CTRL, 0); `CHK(rd, 32'h40)
        apb(0, `SAC_OFF_RESULT, 0); `CHK(rd, 32'h0)
        apb(0, 8'h30, 0); `CHK({er, rd}, 33'h100000000)
        apb(1, `SAC_OFF_REFHI, 32'h5); #1; `CHK(ref_hi_sel, 4'h5)
        strb = 4'h0;
        apb(1, `SAC_OFF_REFHI, 32'hA); #1; `CHK(ref_hi_sel, 4'h5)
        strb = 4'hF;
        apb(1, `SAC_OFF_PA_DIER, 32'h0F);
        apb(1, `SAC_OFF_PB_DIER, 32'hF0);
        apb(0, `SAC_OFF_PA_DATA, 0); `CHK(rd, 32'h0F)
        apb(0, `SAC_OFF_PB_DATA, 0); `CHK(rd, 32'hA0)
        `CHK(pb_din_en, 8'hF0)
        apb(1, `SAC_OFF_IRQ_STAT, 32'h8);
        apb(1, `SAC_OFF_IRQ_MASK, 32'h8);
        for (int i = 0; i < 8; i++)
            conv(i, i);
        conv(0, 3);
        conv(1, 2);
        apb(1, `SAC_OFF_MODE, 32'h3);
        apb(1, `SAC_OFF_CTRL, 32'hC4);
        apb(0, `SAC_OFF_CTRL, 0); `CHK(rd, 32'h84)
        apb(0, `SAC_OFF_RESULT, 0); `CHK(rd, 32'h00)
        apb(1, `SAC_OFF_CTRL, 32'h04);
        repeat (110) @(posedge pclk);
        #1; `CHK(irq, 1'b0)
        apb(0, `SAC_OFF_IRQ_STAT, 0); `CHK(rd, 32'h0)
        apb(0, `SAC_OFF_RESULT, 0); `CHK(rd, 32'h00)
        apb(1, `SAC_OFF_CTRL, 32'h40);
        repeat (4) @(posedge pclk);
        #1; `CHK(sample_en, 1'b0)
        apb(0, `SAC_OFF_CTRL, 0); `CHK(rd, 32'h40)
        apb(1, `SAC_OFF_IRQ_MASK, 32'h0);
        apb(1, `SAC_OFF_CTRL, 32'hC5);
        repeat (100) @(posedge pclk);
        #1; `CHK(irq, 1'b0)
        apb(0, `SAC_OFF_IRQ_STAT, 0); `CHK(rd, 32'h8)
        apb(1, `SAC_OFF_IRQ_MASK, 32'h8); #1; `CHK(irq, 1'b1)
        apb(1, `SAC_OFF_IRQ_STAT, 32'h0); #1; `CHK(irq, 1'b1)
        apb(1, `SAC_OFF_IRQ_STAT, 32'h8); #1; `CHK(irq, 1'b0)
        apb(0, `SAC_OFF_RESULT, 0); `CHK(rd, 32'h80)
        summarize();
    end
endmodule // sac_ctrl_test
bind sac_ctrl sac_ctrl_asserts #(.RES_W(RES_W), .PORT_W(PORT_W)) u_chk (.*);
`default_nettype wire
